// ==== core/gpcg_top.sv ====
// GPIO port clock gating: run, sleep and deep-sleep gate registers on Avalon-MM
//
// Contract
// R1 - Enable bit one in active gating register delivers clock to that port.
// R2 - Enable bit zero in active gating register stops that port's clock.
// R3 - Any access to a port with stopped clock is answered with bus fault.
// R4 - After reset all port enable bits read zero; ports start unclocked.
// R5 - Running operation takes enables from run gating register at 0x108.
// R6 - Sleep uses sleep register at 0x118; deep-sleep uses deep-sleep register.
// R7 - Sleep registers apply only while the auto clock gating bit is set.
// R8 - Bits 7 to 0 enable ports H down to A, each read/write.
// R9 - Bits 31:8 reserved, read zero; software preserves them and ignores them.
// R10 - Software enables each used port before accessing it.
// R11 - Deep-sleep gating register sits at 0x128 with identical layout.
// R12 - Turning a port clock on or off never produces a shortened pulse.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
`include "gpcg_consts.svh"
module gpcg_top
    import gpcg_pkg::*;
(
    // Clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      sys_rst_i,
    // Avalon-MM slave
    input  wire logic [`GPCG_ADDR_W-1:0]   avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire logic [31:0]               avs_writedata_i,
    input  wire logic [3:0]                avs_byteenable_i,
    output logic [31:0]                    avs_readdata_o,
    output logic [1:0]                     avs_response_o,
    output logic                           avs_waitrequest_o,
    // Power mode requests from the system controller
    input  wire logic                      sleep_req_i,
    input  wire logic                      deep_sleep_req_i,
    // Accesses aimed at the port modules
    input  wire gpcg_port_req_t            port_req_i,
    output gpcg_port_resp_t                port_resp_o,
    // Per-port clock enables, bit 0 port A to bit 7 port H
    output logic [`GPCG_NUM_PORTS-1:0]     port_clk_en_o,
    // Interrupt
    output logic                           irq_o
);

    // Gating registers and configuration
    logic [`GPCG_GATE_MSB:0]   run_gate_r;
    logic [`GPCG_GATE_MSB:0]   sleep_gate_r;
    logic [`GPCG_GATE_MSB:0]   deep_gate_r;
    logic                      acg_r;
    gpcg_mode_t                mode_r;
    gpcg_mode_t                mode_nxt;
    logic [`GPCG_GATE_MSB:0]   active_nxt;
    // Bus handshake
    logic                      waitreq_r;
    logic [31:0]               rdata_r;
    logic [1:0]                resp_r;
    logic                      bus_req;
    logic                      bus_take;
    logic                      wr_take;
    logic [31:0]               rd_mux;
    logic                      hit;
    // Port fault path and interrupt
    gpcg_port_resp_t           port_resp_r;
    logic [`GPCG_GATE_MSB:0]   fault_set;
    logic [`GPCG_GATE_MSB:0]   irq_stat_r;
    logic [`GPCG_GATE_MSB:0]   irq_en_r;
    logic [`GPCG_GATE_MSB:0]   irq_clr;
    logic                      irq_r;

    // A request is taken one cycle after it appears, waitrequest falls then
    assign bus_req  = avs_read_i | avs_write_i;
    assign bus_take = bus_req & waitreq_r;
    assign wr_take  = avs_write_i & ~waitreq_r & avs_byteenable_i[0];

    // Mode follows the power controller; deep sleep wins over sleep
    always_comb begin
        if (deep_sleep_req_i) begin
            mode_nxt = GPCG_DEEP;
        end else if (sleep_req_i) begin
            mode_nxt = GPCG_SLEEP;
        end else begin
            mode_nxt = GPCG_RUN;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mode_r <= GPCG_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Select the gating register that governs the present mode
    always_comb begin
        case (mode_r)
            GPCG_RUN: begin
                active_nxt = run_gate_r; // R5
            end
            GPCG_SLEEP: begin
                active_nxt = acg_r ? sleep_gate_r : run_gate_r; // R6 R7
            end
            GPCG_DEEP: begin
                active_nxt = acg_r ? deep_gate_r : run_gate_r; // R6 R7 R11
            end
            default: begin
                active_nxt = run_gate_r;
            end
        endcase
    end

    // One enable stage per port; a set bit clocks the port, a clear bit stops it
    genvar gi;
    generate
        for (gi = 0; gi < `GPCG_NUM_PORTS; gi = gi + 1) begin : g_port
            gpcg_gate_cell u_gate (
                .mclk_i   (mclk_i),
                .sys_rst_i(sys_rst_i),
                .en_i     (active_nxt[gi]),
                .clk_en_o (port_clk_en_o[gi])
            ); // R1 R2 R12
        end
    endgenerate

    // Run gating register, bit n enables port n
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            run_gate_r <= `GPCG_GATE_RST; // R4
        end else if (wr_take && avs_address_i == `GPCG_OFS_RUN_GATE) begin
            run_gate_r <= avs_writedata_i[`GPCG_GATE_MSB:0]; // R8
        end
    end

    // Sleep gating register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sleep_gate_r <= `GPCG_GATE_RST; // R4
        end else if (wr_take && avs_address_i == `GPCG_OFS_SLEEP_GATE) begin
            sleep_gate_r <= avs_writedata_i[`GPCG_GATE_MSB:0]; // R8
        end
    end

    // Deep-sleep gating register, same layout as the other two
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            deep_gate_r <= `GPCG_GATE_RST; // R4
        end else if (wr_take && avs_address_i == `GPCG_OFS_DEEP_GATE) begin
            deep_gate_r <= avs_writedata_i[`GPCG_GATE_MSB:0]; // R11
        end
    end

    // Run configuration: auto clock gating select
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            acg_r <= `GPCG_CFG_ACG_RST;
        end else if (wr_take && avs_address_i == `GPCG_OFS_RUN_CFG) begin
            acg_r <= avs_writedata_i[`GPCG_CFG_ACG_BIT]; // R7
        end
    end

    // Read multiplexer; upper bits of gate registers always read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        case (avs_address_i)
            `GPCG_OFS_RUN_GATE: begin
                rd_mux[`GPCG_GATE_MSB:0] = run_gate_r; // R9
            end
            `GPCG_OFS_SLEEP_GATE: begin
                rd_mux[`GPCG_GATE_MSB:0] = sleep_gate_r; // R9
            end
            `GPCG_OFS_DEEP_GATE: begin
                rd_mux[`GPCG_GATE_MSB:0] = deep_gate_r; // R9
            end
            `GPCG_OFS_RUN_CFG: begin
                rd_mux[`GPCG_CFG_ACG_BIT] = acg_r;
            end
            `GPCG_OFS_STATUS: begin
                rd_mux[`GPCG_STAT_MODE_MSB:`GPCG_STAT_MODE_LSB] = mode_r;
                rd_mux[`GPCG_STAT_EN_MSB:`GPCG_STAT_EN_LSB]     = port_clk_en_o;
            end
            `GPCG_OFS_IRQ_STATUS: begin
                rd_mux[`GPCG_GATE_MSB:0] = irq_stat_r;
            end
            `GPCG_OFS_IRQ_CLEAR: begin
                rd_mux = 32'h0000_0000; // Write-only, reads zero
            end
            `GPCG_OFS_IRQ_ENABLE: begin
                rd_mux[`GPCG_GATE_MSB:0] = irq_en_r;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Waitrequest high while idle, low for exactly one cycle per transfer
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            waitreq_r <= 1'b1;
        end else if (bus_take) begin
            waitreq_r <= 1'b0;
        end else begin
            waitreq_r <= 1'b1;
        end
    end

    // Read data and response are latched as waitrequest falls
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_r <= 32'h0000_0000;
            resp_r  <= `GPCG_RESP_OKAY;
        end else if (bus_take) begin
            rdata_r <= avs_read_i ? rd_mux : 32'h0000_0000;
            resp_r  <= hit ? `GPCG_RESP_OKAY : `GPCG_RESP_DECERR;
        end
    end

    // Accesses to a port are checked against the clock it receives right now,
    // so an access in the same cycle as an enable change sees the old state
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            port_resp_r <= '0;
        end else begin
            port_resp_r.valid <= port_req_i.valid;
            port_resp_r.port  <= port_req_i.port;
            port_resp_r.fault <= port_req_i.valid
                                 & ~port_clk_en_o[port_req_i.port]; // R3
        end
    end

    // One-hot fault event towards the sticky status bits
    always_comb begin
        fault_set = '0;
        if (port_req_i.valid && !port_clk_en_o[port_req_i.port]) begin
            fault_set[port_req_i.port] = 1'b1; // R3
        end
    end

    // Clear strobe from the write-only clear register
    always_comb begin
        irq_clr = '0;
        if (wr_take && avs_address_i == `GPCG_OFS_IRQ_CLEAR) begin
            irq_clr = avs_writedata_i[`GPCG_GATE_MSB:0];
        end
    end

    // Sticky fault status; a new fault outranks a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_stat_r <= `GPCG_IRQ_RST;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | fault_set;
        end
    end

    // Interrupt enable register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_en_r <= `GPCG_IRQ_RST;
        end else if (wr_take && avs_address_i == `GPCG_OFS_IRQ_ENABLE) begin
            irq_en_r <= avs_writedata_i[`GPCG_GATE_MSB:0];
        end
    end

    // Registered level interrupt, one cycle behind the status
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_en_r);
        end
    end

    // Outputs straight from flip-flops
    assign avs_waitrequest_o = waitreq_r;
    assign avs_readdata_o    = rdata_r;
    assign avs_response_o    = resp_r;
    assign port_resp_o       = port_resp_r;
    assign irq_o             = irq_r;

endmodule

// ==== core/gpcg_consts.svh ====
// Register offsets, field positions and reset values of the GPIO port clock gating block
`ifndef GPCG_CONSTS_SVH
`define GPCG_CONSTS_SVH

// Avalon byte address width in bits
`define GPCG_ADDR_W            10
`define GPCG_NUM_PORTS         8

// Register byte offsets
`define GPCG_OFS_RUN_GATE      10'h108
`define GPCG_OFS_SLEEP_GATE    10'h118
`define GPCG_OFS_DEEP_GATE     10'h128
`define GPCG_OFS_RUN_CFG       10'h200
`define GPCG_OFS_STATUS        10'h204
`define GPCG_OFS_IRQ_STATUS    10'h208
`define GPCG_OFS_IRQ_CLEAR     10'h20c
`define GPCG_OFS_IRQ_ENABLE    10'h210

// Field positions
`define GPCG_GATE_MSB          7
`define GPCG_CFG_ACG_BIT       0
`define GPCG_STAT_MODE_LSB     0
`define GPCG_STAT_MODE_MSB     2
`define GPCG_STAT_EN_LSB       8
`define GPCG_STAT_EN_MSB       15

// Reset values
`define GPCG_GATE_RST          8'h00
`define GPCG_CFG_ACG_RST       1'b0
`define GPCG_IRQ_RST           8'h00

// Avalon response codes
`define GPCG_RESP_OKAY         2'b00
`define GPCG_RESP_DECERR       2'b11

`endif

// ==== core/gpcg_pkg.sv ====
// Types shared by the GPIO port clock gating block
package gpcg_pkg;

    // Operating mode, one-hot
    typedef enum logic [2:0] {
        GPCG_RUN   = 3'b001,
        GPCG_SLEEP = 3'b010,
        GPCG_DEEP  = 3'b100
    } gpcg_mode_t;

    // Access from the system bus towards one port module
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [2:0] port;
    } gpcg_port_req_t;

    // Answer to that access: granted or bus fault
    typedef struct packed {
        logic       valid;
        logic       fault;
        logic [2:0] port;
    } gpcg_port_resp_t;

endpackage

// ==== core/gpcg_gate_cell.sv ====
// Per-port clock enable stage feeding the port's clock gate
`timescale 1ns/10ps
module gpcg_gate_cell (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    // Selected enable from the active gating register
    input  wire logic en_i,
    // Registered enable towards the integrated clock gate
    output logic      clk_en_o
);

    // Enable only changes on a rising edge; the downstream latch-based gate
    // then passes whole clock pulses only, so no runt pulse can appear
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            clk_en_o <= 1'b0;
        end else begin
            clk_en_o <= en_i;
        end
    end

endmodule

// ==== verification/gpcg_checker.sv ====
// Concurrent checks on the ports of the port clock gating block
`timescale 1ns/10ps
`include "gpcg_consts.svh"
module gpcg_checker
    import gpcg_pkg::*;
(
    // Clock and reset
    input wire logic                     mclk_i,
    input wire logic                     sys_rst_i,
    // Register bus
    input wire logic [`GPCG_ADDR_W-1:0]  avs_address_i,
    input wire logic                     avs_read_i,
    input wire logic                     avs_write_i,
    input wire logic [31:0]              avs_writedata_i,
    input wire logic [3:0]               avs_byteenable_i,
    input wire logic [31:0]              avs_readdata_o,
    input wire logic                     avs_waitrequest_o,
    // Modes, port accesses, enables, interrupt
    input wire logic                     sleep_req_i,
    input wire logic                     deep_sleep_req_i,
    input wire gpcg_port_req_t           port_req_i,
    input wire gpcg_port_resp_t          port_resp_o,
    input wire logic [`GPCG_NUM_PORTS-1:0] port_clk_en_o,
    input wire logic                     irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    logic [1:0] mode_q_r;
    // Accepted write; only these and mode moves may shift an enable
    wire acc = !avs_waitrequest_o && avs_write_i;
    wire run_wr = acc && avs_address_i == `GPCG_OFS_RUN_GATE && avs_byteenable_i[0];

    // Previous mode inputs, to spot a mode move
    always_ff @(posedge mclk_i) begin
        mode_q_r <= {sleep_req_i, deep_sleep_req_i};
    end

    wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer late");
    port_answer_a: assert property (port_req_i.valid |=> port_resp_o.valid
        && port_resp_o.port == $past(port_req_i.port)) else $error("port answer");
    fault_off_a: assert property (port_req_i.valid && !port_clk_en_o[port_req_i.port]
        |=> port_resp_o.fault) else $error("no fault on gated port");
    grant_on_a: assert property (port_req_i.valid && port_clk_en_o[port_req_i.port]
        |=> !port_resp_o.fault) else $error("fault on clocked port");
    reset_zero_a: assert property ($fell(sys_rst_i) |-> port_clk_en_o == 8'h00 && !irq_o)
        else $error("enable after reset");
    rsvd_zero_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("reserved bits set");
    // Register takes the write, the enable stage follows one edge later
    run_write_a: assert property (run_wr && !sleep_req_i && !deep_sleep_req_i
        |-> ##2 port_clk_en_o == $past(avs_writedata_i[7:0], 2)) else $error("run enables");
    // A write shows two edges later, a mode move also two edges after the inputs change
    enable_cause_a: assert property ($changed(port_clk_en_o) |-> $past(acc, 2)
        || $past(mode_q_r != {sleep_req_i, deep_sleep_req_i}, 2)) else $error("stray enable");
    irq_clear_a: assert property ($fell(irq_o) |-> $past(acc) || $past(acc, 2))
        else $error("irq dropped");

    // Main scenarios
    cover property (port_resp_o.valid && port_resp_o.fault);
    cover property (run_wr);
    cover property ($rose(irq_o));
endmodule

bind gpcg_top gpcg_checker gpcg_checker_i (.mclk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .sleep_req_i, .deep_sleep_req_i, .port_req_i, .port_resp_o, .port_clk_en_o, .irq_o);

// ==== verification/gpcg_port_model.sv ====
// Behavioural port modules and system bus reaching the gated ports
`timescale 1ns/10ps
module gpcg_port_model
    import gpcg_pkg::*;
(
    // Clock
    input  wire logic            mclk_i,
    // Answer from the gating block
    input  wire gpcg_port_resp_t port_resp_i,
    // Accesses towards the ports
    output gpcg_port_req_t       port_req_o
);
    // Idle until the bench asks for an access
    initial port_req_o = '0;

    // Request stands one cycle; a missing answer reads as unknown
    task access(input logic [2:0] p, input logic w, output logic f);
        @(posedge mclk_i);
        port_req_o <= '{valid: 1'b1, write: w, port: p};
        @(posedge mclk_i);
        port_req_o <= '0;
        @(posedge mclk_i);
        f = port_resp_i.valid ? port_resp_i.fault : 1'bx;
    endtask
endmodule

// ==== verification/gpcg_top_tb_top.sv ====
// Self-checking bench for the port clock gating block
`timescale 1ns/10ps
`include "gpcg_consts.svh"
module gpcg_top_tb_top;
    import gpcg_pkg::*;
    logic                    mclk_i = 1'b0;
    logic                    sys_rst_i = 1'b1;
    logic [`GPCG_ADDR_W-1:0] avs_address_i = '0;
    logic                    avs_read_i = 1'b0;
    logic                    avs_write_i = 1'b0;
    logic [31:0]             avs_writedata_i = '0;
    logic [3:0]              avs_byteenable_i = 4'hf;
    logic                    sleep_req_i = 1'b0;
    logic                    deep_sleep_req_i = 1'b0;
    logic [31:0]             avs_readdata_o;
    logic [1:0]              avs_response_o;
    logic                    avs_waitrequest_o;
    gpcg_port_req_t          port_req_i;
    gpcg_port_resp_t         port_resp_o;
    logic [7:0]              port_clk_en_o;
    logic                    irq_o;
    logic [31:0]             q;
    logic [1:0]              r;
    logic                    f;
    int                      err_total = 0;
    int                      checks = 0;

    // 250 MHz clock
    always #2 mclk_i = ~mclk_i;

    gpcg_top gpcg_top_i (.mclk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_response_o,
        .avs_waitrequest_o, .sleep_req_i, .deep_sleep_req_i, .port_req_i, .port_resp_o,
        .port_clk_en_o, .irq_o);
    gpcg_port_model gpcg_port_model_i (.mclk_i, .port_resp_i(port_resp_o), .port_req_o(port_req_i));

    task final_report;
        if (err_total == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One bus transfer; the master never assumes the slave's latency
    task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !w;
        avs_write_i <= w;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 16);
        q = avs_readdata_o;
        r = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (n == 16) begin
            err_total++;
            final_report;
        end
    endtask

    task t_reset;
        logic [9:0] ofs [3];
        ofs = '{`GPCG_OFS_RUN_GATE, `GPCG_OFS_SLEEP_GATE, `GPCG_OFS_DEEP_GATE};
        chk({24'h0, port_clk_en_o}, 32'h0);
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            chk(q, 32'h0);
        end
    endtask

    // Reserved bits written as ones must read back zero; each port probed
    task t_run;
        logic [7:0] m;
        m = 8'ha5;
        bus(1'b1, `GPCG_OFS_RUN_GATE, 32'hffff_ffa5);
        bus(1'b0, `GPCG_OFS_RUN_GATE, 32'h0);
        chk(q, 32'ha5);
        repeat (2) @(posedge mclk_i);
        chk({24'h0, port_clk_en_o}, 32'ha5);
        for (int p = 0; p < 8; p++) begin
            gpcg_port_model_i.access(p[2:0], p[0], f);
            chk({31'h0, f}, {31'h0, !m[p]});
        end
    endtask

    // Unmapped read, and a write with byte lane 0 off that must change nothing
    task t_bad;
        bus(1'b0, 10'h300, 32'h0);
        chk({q[31:2], r}, {30'h0, `GPCG_RESP_DECERR});
        avs_byteenable_i <= 4'h0;
        bus(1'b1, `GPCG_OFS_RUN_GATE, 32'h0);
        avs_byteenable_i <= 4'hf;
        bus(1'b0, `GPCG_OFS_RUN_GATE, 32'h0);
        chk({q[31:2], r}, {30'h29, `GPCG_RESP_OKAY});
    endtask

    task t_mode;
        bus(1'b1, `GPCG_OFS_SLEEP_GATE, 32'h3c);
        bus(1'b1, `GPCG_OFS_DEEP_GATE, 32'hc3);
        bus(1'b0, `GPCG_OFS_DEEP_GATE, 32'h0);
        chk(q, 32'hc3);
        sleep_req_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk({24'h0, port_clk_en_o}, 32'ha5);
        bus(1'b1, `GPCG_OFS_RUN_CFG, 32'h1);
        repeat (2) @(posedge mclk_i);
        chk({24'h0, port_clk_en_o}, 32'h3c);
        deep_sleep_req_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk({24'h0, port_clk_en_o}, 32'hc3);
        bus(1'b0, `GPCG_OFS_STATUS, 32'h0);
        chk(q, 32'h0000_c304);
        sleep_req_i <= 1'b0;
        deep_sleep_req_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk({24'h0, port_clk_en_o}, 32'ha5);
    endtask

    // Fault on gated port B raises, clears, then is masked
    // Faults left by the port probes of the run scenario are cleared first
    task t_irq;
        bus(1'b1, `GPCG_OFS_IRQ_CLEAR, 32'hff);
        bus(1'b1, `GPCG_OFS_IRQ_ENABLE, 32'hff);
        gpcg_port_model_i.access(3'd1, 1'b1, f);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, irq_o}, 32'h1);
        bus(1'b0, `GPCG_OFS_IRQ_STATUS, 32'h0);
        chk(q, 32'h2);
        bus(1'b1, `GPCG_OFS_IRQ_CLEAR, 32'h2);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, `GPCG_OFS_IRQ_ENABLE, 32'h0);
        gpcg_port_model_i.access(3'd1, 1'b0, f);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b0, `GPCG_OFS_IRQ_STATUS, 32'h0);
        chk(q, 32'h2);
    endtask

    // Reset in mid-run: registers, enables and sticky faults return to zero
    task t_rerun;
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        chk({22'h0, irq_o, 1'b0, port_clk_en_o}, 32'h0);
        bus(1'b0, `GPCG_OFS_RUN_GATE, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, `GPCG_OFS_IRQ_STATUS, 32'h0);
        chk(q, 32'h0);
    endtask

    // Reset for four cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset;
        t_run;
        t_bad;
        t_mode;
        t_irq;
        t_rerun;
        final_report;
    end
endmodule
